// [design/davi_pkg.sv]
// davi_pkg: constants and types shared by the delta angle / velocity integrator.
// assumes: 50 MHz system clock, 16-bit serial word map, 2000 SPS sample stream.
package davi_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clocking and timing
   localparam int    CLK_HZ           = 50_000_000;
   localparam int    SAMPLE_SPS       = 2000;
   localparam int    READY_PULSE_NS   = 2000;
   localparam int    READY_PULSE_CYC  = (READY_PULSE_NS * (CLK_HZ / 1_000_000)) / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int    SAMPLE_W         = 32;
   localparam int    ACC_W            = 48;
   localparam int    GAIN_W           = 22;
   localparam int    GAIN_SHIFT       = 24;
   localparam int    DEC_W            = 11;
   localparam int    WORD_W           = 16;
   localparam int    ADDR_W           = 7;
   localparam int    CHAN_N           = 6;

   ////////////////////////////////////////////////////////////////////////////
   // register byte addresses, low word of each pair; high word is two above
   localparam logic [ADDR_W-1:0] X_ANGLE_STEP_LO    = 7'h24;
   localparam logic [ADDR_W-1:0] X_ANGLE_STEP_HI    = 7'h26;
   localparam logic [ADDR_W-1:0] Y_ANGLE_STEP_LO    = 7'h28;
   localparam logic [ADDR_W-1:0] Y_ANGLE_STEP_HI    = 7'h2A;
   localparam logic [ADDR_W-1:0] Z_ANGLE_STEP_LO    = 7'h2C;
   localparam logic [ADDR_W-1:0] Z_ANGLE_STEP_HI    = 7'h2E;
   localparam logic [ADDR_W-1:0] X_VELOCITY_STEP_LO = 7'h30;
   localparam logic [ADDR_W-1:0] X_VELOCITY_STEP_HI = 7'h32;
   localparam logic [ADDR_W-1:0] MAP_BASE           = 7'h24;
   localparam logic [ADDR_W-1:0] MAP_LAST           = 7'h3A;
   localparam logic [WORD_W-1:0] UNMAPPED_WORD      = 16'h0000;
   localparam logic [31:0]       RESULT_RESET       = 32'h0000_0000;
   localparam logic [31:0]       RESULT_MAX         = 32'h7FFF_FFFF;
   localparam logic [31:0]       RESULT_MIN         = 32'h8000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // scale: inputs carry 2^-16 deg/s or m/s^2 per lsb.
   // out = sum(a+b) * 2^-16 / (2*fs) * 2^31 / fs_range, as gain * 2^-GAIN_SHIFT
   localparam longint ANGLE_FS_360    = 360;
   localparam longint ANGLE_FS_720    = 720;
   localparam longint ANGLE_FS_2160   = 2160;
   localparam longint VELOCITY_FS     = 400;
   localparam longint GAIN_NUM        = 64'h0000_0080_0000_0000;
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_360 =
      GAIN_W'(GAIN_NUM / (2 * SAMPLE_SPS * ANGLE_FS_360));
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_720 =
      GAIN_W'(GAIN_NUM / (2 * SAMPLE_SPS * ANGLE_FS_720));
   localparam logic [GAIN_W-1:0] GAIN_ANGLE_2160 =
      GAIN_W'(GAIN_NUM / (2 * SAMPLE_SPS * ANGLE_FS_2160));
   localparam logic [GAIN_W-1:0] GAIN_VELOCITY =
      GAIN_W'(GAIN_NUM / (2 * SAMPLE_SPS * VELOCITY_FS));

   typedef enum logic [1:0] {
      DAVI_RANGE_360  = 2'b00,
      DAVI_RANGE_720  = 2'b01,
      DAVI_RANGE_2160 = 2'b10
   } davi_range_t;

endpackage

// [design/davi_integ.sv]
// davi_integ: one trapezoidal integrator channel with scaled, saturated result.
// assumes: sample_valid_i is a one-cycle strobe per internal sample.
`timescale 1ns/100ps
`default_nettype none
module davi_integ (
   input  wire logic                                  clk_sys_i,
   input  wire logic                                  reset_i,
   input  wire logic                                  sample_valid_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  sample_i,
   input  wire logic                                  close_i,
   input  wire logic        [davi_pkg::GAIN_W-1:0]    gain_i,
   output logic             [31:0]                    result_o
);
   logic signed [davi_pkg::ACC_W-1:0]                 acc_r;
   logic signed [davi_pkg::SAMPLE_W-1:0]              prev_r;
   logic signed [davi_pkg::ACC_W-1:0]                 sum_nxt;
   logic signed [davi_pkg::ACC_W+davi_pkg::GAIN_W:0]  prod;
   logic signed [davi_pkg::ACC_W+davi_pkg::GAIN_W:0]  shifted;
   logic        [31:0]                                sat_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // each sample plus its predecessor; predecessor spans period boundaries
   always_comb begin
      sum_nxt = acc_r + davi_pkg::ACC_W'(sample_i) + davi_pkg::ACC_W'(prev_r);
      prod    = (davi_pkg::ACC_W+davi_pkg::GAIN_W+1)'(sum_nxt)
              * $signed({1'b0, gain_i});
      shifted = prod >>> davi_pkg::GAIN_SHIFT;
      if (shifted > $signed({{(davi_pkg::ACC_W+davi_pkg::GAIN_W-31){1'b0}},
                             davi_pkg::RESULT_MAX})) begin
         sat_nxt = davi_pkg::RESULT_MAX;
      end else if (shifted < $signed({{(davi_pkg::ACC_W+davi_pkg::GAIN_W-31){1'b1}},
                                      davi_pkg::RESULT_MIN})) begin
         sat_nxt = davi_pkg::RESULT_MIN;
      end else begin
         sat_nxt = shifted[31:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         acc_r  <= '0;
         prev_r <= '0;
      end else if (sample_valid_i) begin
         prev_r <= sample_i;
         acc_r  <= close_i ? '0 : sum_nxt;
      end
   end

   // whole 32-bit word replaced at once, so both halves always match
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         result_o <= davi_pkg::RESULT_RESET;
      end else if (sample_valid_i && close_i) begin
         result_o <= sat_nxt;
      end
   end
endmodule
`default_nettype wire

// [design/davi_serial.sv]
// davi_serial: 16-bit serial read port, clock idles high, sampled on rising edge.
// assumes: serial clock well below clk_sys_i / 4; replies one frame later.
`timescale 1ns/100ps
`default_nettype none
module davi_serial (
   input  wire logic                              clk_sys_i,
   input  wire logic                              reset_i,
   input  wire logic                              sclk_i,
   input  wire logic                              cs_n_i,
   input  wire logic                              mosi_i,
   input  wire logic [davi_pkg::WORD_W-1:0]       reply_i,
   output logic      [davi_pkg::ADDR_W-1:0]       addr_o,
   output logic                                   read_req_o,
   output logic                                   miso_o,
   output logic                                   miso_oe_o
);
   logic [2:0]                    sclk_s_r;
   logic [1:0]                    cs_s_r;
   logic                          cs_d_r;
   logic [1:0]                    mosi_s_r;
   logic [davi_pkg::WORD_W-1:0]   rx_r;
   logic [davi_pkg::WORD_W-1:0]   tx_r;
   logic [3:0]                    bit_cnt_r;
   logic                          rise;
   logic                          fall;
   logic                          cs_fall;

   ////////////////////////////////////////////////////////////////////////////
   // pins pass two flops; edge detect looks only at the second and later
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sclk_s_r <= 3'h7;
         cs_s_r   <= 2'h3;
         cs_d_r   <= 1'b1;
         mosi_s_r <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], sclk_i};
         cs_s_r   <= {cs_s_r[0], cs_n_i};
         cs_d_r   <= cs_s_r[1];
         mosi_s_r <= {mosi_s_r[0], mosi_i};
      end
   end

   assign rise    = sclk_s_r[1] & ~sclk_s_r[2] & ~cs_s_r[1];
   assign fall    = ~sclk_s_r[1] & sclk_s_r[2] & ~cs_s_r[1];
   assign cs_fall = ~cs_s_r[1] & cs_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // receive; first bit low marks a read, next seven bits the byte address
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rx_r       <= '0;
         bit_cnt_r  <= '0;
         addr_o     <= '0;
         read_req_o <= 1'b0;
      end else begin
         read_req_o <= 1'b0;
         if (cs_s_r[1]) begin
            bit_cnt_r <= '0;
         end else if (rise) begin
            rx_r      <= {rx_r[davi_pkg::WORD_W-2:0], mosi_s_r[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'hF && !rx_r[davi_pkg::WORD_W-2]) begin
               addr_o     <= rx_r[davi_pkg::WORD_W-3:davi_pkg::WORD_W-9];
               read_req_o <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmit; word loaded two cycles after select so reply_i has settled
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tx_r      <= '0;
         miso_o    <= 1'b0;
         miso_oe_o <= 1'b0;
      end else begin
         miso_oe_o <= ~cs_s_r[1];
         if (cs_fall) begin
            tx_r <= reply_i;
         end else if (fall) begin
            miso_o <= tx_r[davi_pkg::WORD_W-1];
            tx_r   <= {tx_r[davi_pkg::WORD_W-2:0], 1'b0};
         end
      end
   end
endmodule
`default_nettype wire

// [design/davi_top.sv]
// davi_top: three-axis delta angle and delta velocity integrators with word map.
// assumes: core delivers gyro and accel samples on clk_sys_i with one strobe.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - velocity is trapezoid sum over period, halved rate
// - samples per output equal setting plus one
// - scale assumes nominal 2000 samples per second
// - angle is two 16-bit words per axis
// - pairs at 0x24, 0x28, 0x2C, low first
// - upper word two's complement, full scale/2^15
// - upper word spans 0x8000 through 0x7FFF
// - combined word two's complement, full scale/2^31
// - velocity words arranged like angle words
// - accumulation restarts at every output update
// - angle is trapezoid sum of rate samples
// - angle full scale selectable 360, 720, 2160
// - velocity upper word spans plus/minus 400 m/s
module davi_top (
   input  wire logic                                  clk_sys_i,
   input  wire logic                                  reset_i,
   input  wire logic                                  sample_valid_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  gyro_x_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  gyro_y_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  gyro_z_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  accel_x_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  accel_y_i,
   input  wire logic signed [davi_pkg::SAMPLE_W-1:0]  accel_z_i,
   input  wire logic        [davi_pkg::DEC_W-1:0]     decimation_setting_i,
   input  wire logic        [1:0]                     angle_range_i,
   input  wire logic                                  sclk_i,
   input  wire logic                                  cs_n_i,
   input  wire logic                                  mosi_i,
   output logic                                       miso_o,
   output logic                                       miso_oe_o,
   output logic                                       sample_ready_pin_o
);

   ////////////////////////////////////////////////////////////////////////////
   // word decode: channel index and half for a byte address
   function automatic logic [3:0] word_index(input logic [davi_pkg::ADDR_W-1:0] a);
      logic [davi_pkg::ADDR_W-1:0] off;
      off = a - davi_pkg::MAP_BASE;
      if (a < davi_pkg::MAP_BASE || a > davi_pkg::MAP_LAST + 7'h1) begin
         word_index = 4'hF;
      end else begin
         word_index = off[4:1];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // samples and gains per channel: 0..2 angle, 3..5 velocity
   logic signed [davi_pkg::SAMPLE_W-1:0] chan_sample [davi_pkg::CHAN_N];
   logic        [davi_pkg::GAIN_W-1:0]   chan_gain   [davi_pkg::CHAN_N];
   logic        [31:0]                   chan_result [davi_pkg::CHAN_N];
   logic        [davi_pkg::GAIN_W-1:0]   angle_gain_r;
   logic        [davi_pkg::DEC_W-1:0]    dec_cnt_r;
   logic        [davi_pkg::DEC_W-1:0]    dec_setting_r;
   logic                                 close;
   logic        [7:0]                    ready_cnt_r;
   logic        [davi_pkg::ADDR_W-1:0]   rd_addr;
   logic                                 rd_req;
   logic        [davi_pkg::WORD_W-1:0]   reply_r;
   logic        [3:0]                    widx;

   assign chan_sample[0] = gyro_x_i;
   assign chan_sample[1] = gyro_y_i;
   assign chan_sample[2] = gyro_z_i;
   assign chan_sample[3] = accel_x_i;
   assign chan_sample[4] = accel_y_i;
   assign chan_sample[5] = accel_z_i;

   ////////////////////////////////////////////////////////////////////////////
   // angle full scale; changed between samples takes effect at next close
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         angle_gain_r <= davi_pkg::GAIN_ANGLE_360;
      end else begin
         case (davi_pkg::davi_range_t'(angle_range_i))
            davi_pkg::DAVI_RANGE_360:  angle_gain_r <= davi_pkg::GAIN_ANGLE_360;
            davi_pkg::DAVI_RANGE_720:  angle_gain_r <= davi_pkg::GAIN_ANGLE_720;
            davi_pkg::DAVI_RANGE_2160: angle_gain_r <= davi_pkg::GAIN_ANGLE_2160;
            default:                   angle_gain_r <= davi_pkg::GAIN_ANGLE_2160;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // decimation: setting held for a whole period so a change never splits one
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         dec_cnt_r     <= '0;
         dec_setting_r <= '0;
      end else if (sample_valid_i) begin
         if (close) begin
            dec_cnt_r     <= '0;
            dec_setting_r <= decimation_setting_i;
         end else begin
            dec_cnt_r <= dec_cnt_r + davi_pkg::DEC_W'(1);
         end
      end
   end

   assign close = (dec_cnt_r >= dec_setting_r);

   ////////////////////////////////////////////////////////////////////////////
   // integrator channels
   genvar g;
   generate
      for (g = 0; g < davi_pkg::CHAN_N; g++) begin : g_chan
         assign chan_gain[g] = (g < 3) ? angle_gain_r : davi_pkg::GAIN_VELOCITY;
         davi_integ u_integ (
            .clk_sys_i      (clk_sys_i),
            .reset_i        (reset_i),
            .sample_valid_i (sample_valid_i),
            .sample_i       (chan_sample[g]),
            .close_i        (close),
            .gain_i         (chan_gain[g]),
            .result_o       (chan_result[g])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // ready pulse once per output update, a fixed width long
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ready_cnt_r        <= '0;
         sample_ready_pin_o <= 1'b0;
      end else begin
         if (sample_valid_i && close) begin
            ready_cnt_r        <= 8'(davi_pkg::READY_PULSE_CYC - 1);
            sample_ready_pin_o <= 1'b1;
         end else if (ready_cnt_r != 8'h00) begin
            ready_cnt_r <= ready_cnt_r - 8'h01;
         end else begin
            sample_ready_pin_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read map: even index low half, odd index high half of one result
   assign widx = word_index(rd_addr);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         reply_r <= davi_pkg::UNMAPPED_WORD;
      end else if (rd_req) begin
         if (widx == 4'hF || widx[3:1] > 3'h5) begin
            reply_r <= davi_pkg::UNMAPPED_WORD;
         end else if (widx[0]) begin
            reply_r <= chan_result[widx[3:1]][31:16];
         end else begin
            reply_r <= chan_result[widx[3:1]][15:0];
         end
      end
   end

   davi_serial u_serial (
      .clk_sys_i  (clk_sys_i),
      .reset_i    (reset_i),
      .sclk_i     (sclk_i),
      .cs_n_i     (cs_n_i),
      .mosi_i     (mosi_i),
      .reply_i    (reply_r),
      .addr_o     (rd_addr),
      .read_req_o (rd_req),
      .miso_o     (miso_o),
      .miso_oe_o  (miso_oe_o)
   );
endmodule
`default_nettype wire

// [tb/davi_host.sv]
// davi_host: serial host that clocks 16-bit frames into the integrator block.
// assumes: clock idles high, reply comes back in the frame after the request.
`timescale 1ns/100ps
`default_nettype none
module davi_host (
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o,
   input  wire logic miso_i,
   input  wire logic miso_oe_i
);
   logic miso_w;
   // released line floats to the pull-up level
   assign miso_w = miso_oe_i ? miso_i : 1'b1;
   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   // sample late in the high phase: miso lags the falling edge by a few cycles
   task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
      rsp = 16'h0000;
      cs_n_o = 1'b0;
      #80;
      for (int i = 15; i >= 0; i--) begin
         sclk_o = 1'b0;
         mosi_o = cmd[i];
         #80;
         sclk_o = 1'b1;
         #70;
         rsp = {rsp[14:0], miso_w};
         #10;
      end
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      #320;
   endtask
endmodule
`default_nettype wire

// [tb/davi_top_chk.sv]
// davi_top_chk: port-level timing checks for the integrator block.
// assumes: bound to davi_top; serial lines come from an outside host.
`timescale 1ns/100ps
`default_nettype none
module davi_top_chk (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic sample_valid_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic miso_o,
   input wire logic miso_oe_o,
   input wire logic sample_ready_pin_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   logic [7:0] hi_run_r;
   logic [7:0] quiet_r;
   logic [3:0] sck_hi_r;
   // saturating counts, so long idle spans never wrap
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !sample_ready_pin_o) hi_run_r <= 8'h00;
      else if (hi_run_r != 8'hFF) hi_run_r <= hi_run_r + 8'h01;
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || sample_valid_i) quiet_r <= 8'h00;
      else if (quiet_r != 8'hFF) quiet_r <= quiet_r + 8'h01;
   end
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !sclk_i) sck_hi_r <= 4'h0;
      else if (sck_hi_r != 4'hF) sck_hi_r <= sck_hi_r + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_ready_cause; $rose(sample_ready_pin_o) |-> $past(sample_valid_i); endproperty
   a_ready_cause: assert property (p_ready_cause)
      else $error("ready rose without a sample strobe");
   property p_ready_min;
      $fell(sample_ready_pin_o) && !$past(reset_i) |-> hi_run_r >= 8'h64;
   endproperty
   a_ready_min: assert property (p_ready_min)
      else $error("ready pulse shorter than 100 cycles");
   property p_ready_quiet; quiet_r >= 8'h64 |-> !sample_ready_pin_o; endproperty
   a_ready_quiet: assert property (p_ready_quiet)
      else $error("ready still high 100 cycles after last strobe");
   property p_reset_clear; $fell(reset_i) |-> !sample_ready_pin_o && !miso_oe_o; endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not idle after reset");
   property p_oe_on; (!cs_n_i)[*8] |-> miso_oe_o; endproperty
   a_oe_on: assert property (p_oe_on)
      else $error("miso not driven while selected");
   property p_oe_off; (cs_n_i)[*8] |-> !miso_oe_o; endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("miso driven while deselected");
   property p_oe_rise; $rose(miso_oe_o) |-> !$past(cs_n_i, 2); endproperty
   a_oe_rise: assert property (p_oe_rise)
      else $error("miso enabled before select");
   property p_miso_hold;
      miso_oe_o && $past(miso_oe_o) && !cs_n_i && $changed(miso_o) |-> sck_hi_r < 4'h3;
   endproperty
   a_miso_hold: assert property (p_miso_hold)
      else $error("miso changed late in the clock high phase");
   c_update: cover property ($rose(sample_ready_pin_o));
   c_pulse_end: cover property ($fell(sample_ready_pin_o));
   c_frame: cover property ($rose(miso_oe_o));
endmodule
bind davi_top davi_top_chk u_chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
   .sample_valid_i(sample_valid_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .miso_o(miso_o),
   .miso_oe_o(miso_oe_o), .sample_ready_pin_o(sample_ready_pin_o));
`default_nettype wire

// [tb/davi_top_bench.sv]
// davi_top_bench: row-driven samples, read-back of the whole word map.
// assumes: davi_host clocks the frames; expected words come from a local model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module davi_top_bench;
   typedef struct {logic [10:0] dec; logic [1:0] rng; logic [31:0] g; logic [31:0] a;} davi_row_t;
   // row 2 saturates both ways; row 5 is the longest period
   davi_row_t rows [6] = '{'{11'h000, 2'h0, 32'h0001_0000, 32'h0002_0000},
      '{11'h003, 2'h1, 32'h0123_4567, 32'hFEDC_BA98},
      '{11'h01E, 2'h0, 32'h7FFF_FFFF, 32'h7FFF_FFFF},
      '{11'h007, 2'h2, 32'hFFF0_0000, 32'h0800_0000},
      '{11'h001, 2'h3, 32'h0040_0000, 32'hFFC0_0000},
      '{11'h7FF, 2'h0, 32'h0000_1000, 32'h0000_0100}};
   logic                             clk_sys_i, reset_i, sample_valid_i;
   logic                             sclk, cs_n, mosi, miso, miso_oe, ready;
   logic signed [31:0]               smp [6];
   logic        [davi_pkg::DEC_W-1:0] dec_set;
   logic        [1:0]                angle_range;
   logic        [31:0]               exp_r [6];
   longint                           acc [6], prv [6];
   int                               cnt, len, num_errors, check_count;

   davi_top u_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sample_valid_i(sample_valid_i),
      .gyro_x_i(smp[0]), .gyro_y_i(smp[1]), .gyro_z_i(smp[2]), .accel_x_i(smp[3]),
      .accel_y_i(smp[4]), .accel_z_i(smp[5]), .decimation_setting_i(dec_set),
      .angle_range_i(angle_range), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso),
      .miso_oe_o(miso_oe), .sample_ready_pin_o(ready));
   davi_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
      .miso_oe_i(miso_oe));
   ////////////////////////////////////////////////////////////////////////////
   function automatic longint gain_of(int c);
      if (c > 2) return longint'(davi_pkg::GAIN_VELOCITY);
      case (angle_range)
         2'h0: return longint'(davi_pkg::GAIN_ANGLE_360);
         2'h1: return longint'(davi_pkg::GAIN_ANGLE_720);
         default: return longint'(davi_pkg::GAIN_ANGLE_2160);
      endcase
   endfunction
   function automatic logic [31:0] scale(int c);
      longint r;
      r = (acc[c] * gain_of(c)) >>> 24;
      if (r > longint'(signed'(davi_pkg::RESULT_MAX))) return davi_pkg::RESULT_MAX;
      if (r < longint'(signed'(davi_pkg::RESULT_MIN))) return davi_pkg::RESULT_MIN;
      return r[31:0];
   endfunction
   task automatic model_clear();
      for (int c = 0; c < 6; c++) begin
         acc[c] = 0;
         prv[c] = 0;
         exp_r[c] = davi_pkg::RESULT_RESET;
      end
      cnt = 0;
      len = int'(dec_set) + 1;
   endtask
   task automatic do_reset();
      reset_i = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      reset_i = 1'b0;
      model_clear();
   endtask
   task automatic load(logic [31:0] g, logic [31:0] a);
      smp = '{g, ~g, {g[31], g[31:1]}, a, ~a, {a[31], a[31:1]}};
   endtask
   // trapezoid term per strobe; prior sample carries over the period boundary
   task automatic strobe();
      @(posedge clk_sys_i);
      #1;
      sample_valid_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      sample_valid_i = 1'b0;
      for (int c = 0; c < 6; c++) begin
         acc[c] += longint'(smp[c]) + prv[c];
         prv[c] = longint'(smp[c]);
      end
      cnt++;
      if (cnt == len) begin
         for (int c = 0; c < 6; c++) exp_r[c] = scale(c);
         acc = '{6{64'sh0}};
         cnt = 0;
         len = int'(dec_set) + 1;
         `CHK("ready", 1'b1, ready)
      end
      repeat (2) @(posedge clk_sys_i);
      #1;
   endtask
   // twelve map words, an odd address, an unmapped one, a refused write
   task automatic check_map();
      logic [15:0] cmd [16];
      logic [15:0] w [16];
      logic [15:0] got;
      w[0] = davi_pkg::UNMAPPED_WORD;
      for (int k = 0; k < 12; k++) begin
         cmd[k] = {1'b0, davi_pkg::MAP_BASE + 7'(2 * k), 8'h00};
         w[k+1] = k[0] ? exp_r[k/2][31:16] : exp_r[k/2][15:0];
      end
      cmd[12] = {1'b0, davi_pkg::X_ANGLE_STEP_HI + 7'h01, 8'h00};
      w[13] = exp_r[0][31:16];
      cmd[13] = 16'h1000;
      w[14] = davi_pkg::UNMAPPED_WORD;
      cmd[14] = {1'b1, davi_pkg::X_ANGLE_STEP_LO, 8'h00};
      w[15] = davi_pkg::UNMAPPED_WORD;
      cmd[15] = 16'h0000;
      for (int k = 0; k < 16; k++) begin
         u_host.xfer(cmd[k], got);
         `CHK($sformatf("word %0d", k), w[k], got)
      end
      @(posedge clk_sys_i);
      #1;
   endtask
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      #1_500_000;
      num_errors++;
      stop_test();
   end
   initial begin
      num_errors = 0;
      check_count = 0;
      sample_valid_i = 1'b0;
      angle_range = 2'h0;
      dec_set = '0; // zero at every reset so the first period is one strobe
      load(32'h0, 32'h0);
      do_reset();
      check_map();
      for (int r = 0; r < 6; r++) begin
         load(rows[r].g, rows[r].a);
         dec_set = rows[r].dec;
         angle_range = rows[r].rng;
         do strobe(); while (cnt != 0); // old length still applies
         do strobe(); while (cnt != 0);
         check_map();
      end
      // reset in mid-period: partial sum and carried sample both dropped
      dec_set = '0;
      repeat (5) strobe();
      do_reset();
      check_map();
      load(32'h0010_0000, 32'hFFF0_0000);
      strobe();
      check_map();
      stop_test();
   end
endmodule
`default_nettype wire
